// ---- core/operand_address_generator.sv ----
// Operand address generator: resolves one decoded operand per request.
// Assumes decoder and register file on i_clock; one-cycle answer latency.

// Operation
// [RULE1] Multiply takes accumulator byte, writes product into accumulator pair.
// [RULE2] Word divide uses accumulator pair as dividend and quotient.
// [RULE3] Decimal adjusts implicitly select the accumulator byte.
// [RULE4] Digit rotates implicitly select the accumulator byte.
// [RULE5] Register mode picks one of eight registers by 3-bit field and bank.
// [RULE6] Eight byte registers and four pairs, named by number or function.
// [RULE7] Direct mode uses 16-bit immediate as operand address, whole space.
// [RULE8] Short direct byte selects within FE20H..FF1FH window.
// [RULE9] FE20H..FEFFH is fast RAM, FF00H..FF1FH special registers.
// [RULE10] Address bit 8 cleared for 20H..FFH, set for 00H..1FH.
// [RULE11] Short direct forces bits 15..9 high, byte in bits 7..0.
// [RULE12] Word short direct operands sit at even addresses only.
// [RULE13] Special-register byte reaches FF00H..FFCFH and FFE0H..FFFFH.
// [RULE14] Word special registers must permit word access, even address. Code flags only an odd address, with no per-register word-access check.
// [RULE15] Register indirect uses selected bank DE or base pair as address.
// [RULE16] Based adds zero-extended byte to base pair, carry dropped.
// [RULE17] Based indexed adds zero-extended B or C to base pair, carry dropped.
// [RULE18] Opcode 10101011 loads accumulator from base pair plus B.
// [RULE19] Push, pop, call, return, interrupt save address through stack pointer.
// [RULE20] Stack lies only in internal fast RAM.
module operand_address_generator (
    input  wire logic                      i_clock,
    input  wire logic                      i_srst,
    input  wire logic                      i_valid,
    input  wire opaddr_pkg::decode_req_t   i_req,
    input  wire logic                      i_bank_select_bit_low,
    input  wire logic                      i_bank_select_bit_high,
    input  wire logic [15:0]               i_base_pointer_pair,
    input  wire logic [15:0]               i_index_pair,
    input  wire logic [7:0]                i_reg_b,
    input  wire logic [7:0]                i_reg_c,
    input  wire logic [15:0]               i_stack_pointer,
    output logic                           o_valid,
    output opaddr_pkg::operand_t           o_operand
);

    // ****************************************************************
    // Combinational resolution
    // ****************************************************************
    logic [1:0]            bank;
    opaddr_pkg::operand_t  res_d;
    logic [16:0]           base_sum;
    logic [7:0]            index_byte;

    assign bank = {i_bank_select_bit_high, i_bank_select_bit_low};

    // Index byte selection and base addition
    always_comb begin
        // [RULE18] fixed opcode forces B index
        if (i_req.opcode == opaddr_pkg::OPC_LOAD_A_BASE_B) begin
            index_byte = i_reg_b;
        end else if (i_req.use_c_index) begin
            index_byte = i_reg_c;
        end else begin
            index_byte = i_reg_b;
        end
        // [RULE16] based offset zero extended
        if (i_req.mode == opaddr_pkg::mode_based) begin
            base_sum = {1'b0, i_base_pointer_pair} + {9'h000, i_req.imm[7:0]};
        end else begin
            // [RULE17] indexed byte zero extended
            base_sum = {1'b0, i_base_pointer_pair} + {9'h000, index_byte};
        end
    end

    // Mode decode into the operand descriptor
    always_comb begin
        res_d           = '0;
        res_d.dest_abs  = {bank, opaddr_pkg::REG_A};
        // [RULE18] forced based indexed load
        if (i_req.opcode == opaddr_pkg::OPC_LOAD_A_BASE_B) begin
            res_d.is_mem = 1'b1;
            res_d.addr   = base_sum[15:0];
        end else begin
            case (i_req.mode)
                opaddr_pkg::mode_implied: begin
                    res_d.is_reg  = 1'b1;
                    res_d.reg_abs = {bank, opaddr_pkg::REG_A};
                    case (i_req.imp_op)
                        // [RULE1] multiply into pair
                        opaddr_pkg::imp_unsigned_byte_multiply: begin
                            res_d.dest_abs  = {bank, opaddr_pkg::PAIR_ACC, 1'b0};
                            res_d.dest_pair = 1'b1;
                        end
                        // [RULE2] divide on pair
                        opaddr_pkg::imp_unsigned_word_divide: begin
                            res_d.is_pair   = 1'b1;
                            res_d.reg_abs   = {bank, opaddr_pkg::PAIR_ACC, 1'b0};
                            res_d.dest_abs  = {bank, opaddr_pkg::PAIR_ACC, 1'b0};
                            res_d.dest_pair = 1'b1;
                        end
                        // [RULE3] decimal adjust on accumulator
                        opaddr_pkg::imp_decimal_adjust_after_add,
                        opaddr_pkg::imp_decimal_adjust_after_sub: begin
                            res_d.dest_abs = {bank, opaddr_pkg::REG_A};
                        end
                        // [RULE4] digit rotate on accumulator
                        opaddr_pkg::imp_digit_rotate_right,
                        opaddr_pkg::imp_digit_rotate_left: begin
                            res_d.dest_abs = {bank, opaddr_pkg::REG_A};
                        end
                        default: begin
                            res_d.dest_abs = {bank, opaddr_pkg::REG_A};
                        end
                    endcase
                end
                // [RULE5] [RULE6] banked register select
                opaddr_pkg::mode_register: begin
                    res_d.is_reg  = 1'b1;
                    res_d.is_pair = i_req.word;
                    if (i_req.word) begin
                        res_d.reg_abs = {bank, i_req.pair_field, 1'b0};
                    end else begin
                        res_d.reg_abs = {bank, i_req.reg_field};
                    end
                    res_d.dest_abs  = res_d.reg_abs;
                    res_d.dest_pair = i_req.word;
                end
                // [RULE7] absolute operand address
                opaddr_pkg::mode_direct: begin
                    res_d.is_mem     = 1'b1;
                    res_d.addr       = i_req.imm;
                    res_d.misaligned = i_req.word & i_req.imm[0];
                end
                // [RULE8] [RULE9] [RULE10] [RULE11] short direct window
                opaddr_pkg::mode_short_direct: begin
                    res_d.is_mem = 1'b1;
                    res_d.addr   = {opaddr_pkg::SHORT_HIGH,
                                    (i_req.imm[7:0] < opaddr_pkg::SHORT_SPLIT),
                                    i_req.imm[7:0]};
                    // [RULE12] odd word flagged
                    res_d.misaligned = i_req.word & i_req.imm[0];
                end
                // [RULE13] special register page
                opaddr_pkg::mode_special_reg: begin
                    res_d.is_mem   = 1'b1;
                    res_d.addr     = {opaddr_pkg::SFR_BASE[15:8], i_req.imm[7:0]};
                    res_d.unmapped = (i_req.imm[7:0] >= opaddr_pkg::SFR_GAP_LO) &&
                                     (i_req.imm[7:0] <= opaddr_pkg::SFR_GAP_HI);
                    // [RULE14] odd word flagged
                    res_d.misaligned = i_req.word & i_req.imm[0];
                end
                // [RULE15] pair contents as address
                opaddr_pkg::mode_reg_indirect: begin
                    res_d.is_mem = 1'b1;
                    if (i_req.pair_field == opaddr_pkg::PAIR_DE) begin
                        res_d.addr = i_index_pair;
                    end else begin
                        res_d.addr = i_base_pointer_pair;
                    end
                end
                opaddr_pkg::mode_based,
                opaddr_pkg::mode_based_indexed: begin
                    res_d.is_mem = 1'b1;
                    res_d.addr   = base_sum[15:0];
                end
                // [RULE19] stack pointer addressing
                opaddr_pkg::mode_stack: begin
                    res_d.is_mem   = 1'b1;
                    res_d.is_stack = 1'b1;
                    res_d.addr     = i_stack_pointer;
                    // [RULE20] outside fast RAM flagged
                    res_d.unmapped = (i_stack_pointer < opaddr_pkg::SHORT_LO_ADDR) ||
                                     (i_stack_pointer > opaddr_pkg::SFR_BASE - 16'h0001);
                end
                default: begin
                    res_d.unmapped = 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // Output registers
    // ****************************************************************
    // Answer valid one cycle after request
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_valid <= 1'b0;
        end else begin
            o_valid <= i_valid;
        end
    end

    // Operand descriptor capture
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_operand <= '0;
        end else if (i_valid) begin
            o_operand <= res_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    logic is_short;
    assign is_short = i_valid && i_req.mode == opaddr_pkg::mode_short_direct &&
                      i_req.opcode != opaddr_pkg::OPC_LOAD_A_BASE_B;

    a_short_bit_eight: assert property ( // [RULE10]
        is_short |=> o_operand.addr[8] == ($past(i_req.imm[7:0]) < 8'h20))
        else $error("short direct bit 8 wrong");
    a_short_window: assert property ( // [RULE8]
        is_short |=> o_operand.addr >= opaddr_pkg::SHORT_LO_ADDR &&
                     o_operand.addr <= opaddr_pkg::SHORT_HI_ADDR)
        else $error("short direct outside window");
    a_short_high_bits: assert property ( // [RULE11]
        is_short |=> o_operand.addr[15:9] == 7'h7f &&
                     o_operand.addr[7:0] == $past(i_req.imm[7:0]))
        else $error("short direct high bits wrong");
    a_direct_addr: assert property ( // [RULE7]
        i_valid && i_req.mode == opaddr_pkg::mode_direct &&
        i_req.opcode != opaddr_pkg::OPC_LOAD_A_BASE_B
        |=> o_operand.addr == $past(i_req.imm) && o_operand.is_mem)
        else $error("direct address wrong");
    a_based_sum: assert property ( // [RULE16]
        i_valid && i_req.mode == opaddr_pkg::mode_based &&
        i_req.opcode != opaddr_pkg::OPC_LOAD_A_BASE_B
        |=> o_operand.addr == 16'($past(i_base_pointer_pair) + $past(i_req.imm[7:0])))
        else $error("based sum wrong");
    a_fixed_opcode: assert property ( // [RULE18]
        i_valid && i_req.opcode == opaddr_pkg::OPC_LOAD_A_BASE_B
        |=> o_operand.addr == 16'($past(i_base_pointer_pair) + $past(i_reg_b)))
        else $error("fixed opcode index wrong");
    a_register_bank: assert property ( // [RULE5]
        i_valid && i_req.mode == opaddr_pkg::mode_register && !i_req.word &&
        i_req.opcode != opaddr_pkg::OPC_LOAD_A_BASE_B
        |=> o_operand.reg_abs == {$past(bank), $past(i_req.reg_field)})
        else $error("register bank select wrong");
    a_stack_pointer: assert property ( // [RULE19]
        i_valid && i_req.mode == opaddr_pkg::mode_stack &&
        i_req.opcode != opaddr_pkg::OPC_LOAD_A_BASE_B
        |=> o_operand.is_stack && o_operand.addr == $past(i_stack_pointer))
        else $error("stack address wrong");
    a_valid_delay: assert property (
        i_valid |=> o_valid)
        else $error("answer not one cycle later");

endmodule : operand_address_generator

// ---- common/opaddr_pkg.sv ----
// Package for the operand address generator: modes, register numbers, windows.
// Assumes a byte-wide register file of four banks of eight registers.
package opaddr_pkg;

    // ****************************************************************
    // Operand addressing modes
    // ****************************************************************
    typedef enum logic [3:0] {
        mode_implied,
        mode_register,
        mode_direct,
        mode_short_direct,
        mode_special_reg,
        mode_reg_indirect,
        mode_based,
        mode_based_indexed,
        mode_stack
    } addr_mode_t;

    // Implied-operand instruction classes
    typedef enum logic [2:0] {
        imp_none,
        imp_unsigned_byte_multiply,
        imp_unsigned_word_divide,
        imp_decimal_adjust_after_add,
        imp_decimal_adjust_after_sub,
        imp_digit_rotate_right,
        imp_digit_rotate_left
    } implied_op_t;

    // Stack operation kinds
    typedef enum logic [2:0] {
        stk_push,
        stk_pop,
        stk_call,
        stk_return,
        stk_irq_save
    } stack_op_t;

    // Byte register numbers by functional name
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_D = 3'h5;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_H = 3'h7;
    // Register pair numbers
    localparam logic [1:0] PAIR_ACC  = 2'h0;
    localparam logic [1:0] PAIR_BC   = 2'h1;
    localparam logic [1:0] PAIR_DE   = 2'h2;
    localparam logic [1:0] PAIR_BASE = 2'h3;

    // Opcode of load accumulator from base pointer plus B
    localparam logic [7:0] OPC_LOAD_A_BASE_B = 8'hab;

    // Short direct window, its split, and the special register page with its unmapped gap
    localparam logic [7:0]  SHORT_SPLIT    = 8'h20;
    localparam logic [6:0]  SHORT_HIGH     = 7'h7f;
    localparam logic [15:0] SHORT_LO_ADDR  = 16'hfe20;
    localparam logic [15:0] SHORT_HI_ADDR  = 16'hff1f;
    localparam logic [15:0] SFR_BASE       = 16'hff00;
    localparam logic [7:0]  SFR_GAP_LO     = 8'hd0;
    localparam logic [7:0]  SFR_GAP_HI     = 8'hdf;

    // Reset values
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [2:0]  REG_RESET  = 3'h0;

    // Request from the instruction decoder
    typedef struct packed {
        addr_mode_t  mode;
        implied_op_t imp_op;
        stack_op_t   stk_op;
        logic [7:0]  opcode;
        logic [2:0]  reg_field;
        logic [1:0]  pair_field;
        logic        word;
        logic        use_c_index;
        logic [15:0] imm;
    } decode_req_t;

    // Resolved operand
    typedef struct packed {
        logic        is_reg;
        logic        is_pair;
        logic [4:0]  reg_abs;
        logic        is_mem;
        logic [15:0] addr;
        logic        is_stack;
        logic        misaligned;
        logic        unmapped;
        logic [4:0]  dest_abs;
        logic        dest_pair;
    } operand_t;

endpackage : opaddr_pkg

// ---- dv/regfile_model.sv ----
// Banked register file and stack pointer feeding the operand address generator.
// Assumes the bench writes it on the rising edge of i_clock; reads are immediate.
module regfile_model (
    input  wire logic        i_clock,
    input  wire logic        i_wr,
    input  wire logic [4:0]  i_wr_sel,
    input  wire logic [7:0]  i_wr_data,
    input  wire logic        i_sp_wr,
    input  wire logic [15:0] i_sp_data,
    input  wire logic        i_bank_select_bit_low,
    input  wire logic        i_bank_select_bit_high,
    output logic      [15:0] o_base_pointer_pair,
    output logic      [15:0] o_index_pair,
    output logic      [7:0]  o_reg_b,
    output logic      [7:0]  o_reg_c,
    output logic      [15:0] o_stack_pointer
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  regs_q [32];
    logic [15:0] sp_q;
    logic [1:0]  bank;
    // Register and stack pointer writes
    always_ff @(posedge i_clock) begin
        if (i_wr) regs_q[i_wr_sel] <= i_wr_data;
        if (i_sp_wr) sp_q <= i_sp_data;
    end
    // Selected bank views
    assign bank = {i_bank_select_bit_high, i_bank_select_bit_low};
    assign o_base_pointer_pair = {regs_q[{bank, 3'h7}], regs_q[{bank, 3'h6}]};
    assign o_index_pair = {regs_q[{bank, 3'h5}], regs_q[{bank, 3'h4}]};
    assign o_reg_b = regs_q[{bank, 3'h3}];
    assign o_reg_c = regs_q[{bank, 3'h2}];
    assign o_stack_pointer = sp_q;
endmodule : regfile_model

// ---- dv/operand_address_generator_tb_top.sv ----
// Self-checking bench for the operand address generator.
// Assumes one-cycle answer latency; stimulus changes on the falling edge.
module operand_address_generator_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     i_clock, i_srst, i_valid, wr, sp_wr, bsl, bsh, o_valid;
    logic [4:0]               wr_sel;
    logic [7:0]               wr_data, rb, rc;
    logic [15:0]              sp_data, hl, de, sp;
    opaddr_pkg::decode_req_t  i_req;
    opaddr_pkg::operand_t     o;
    int                       failures, check_count, cycles;
    // ****************************************************************
    // Clock, design and partner
    // ****************************************************************
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    operand_address_generator dut (.i_clock(i_clock), .i_srst(i_srst), .i_valid(i_valid),
        .i_req(i_req), .i_bank_select_bit_low(bsl), .i_bank_select_bit_high(bsh),
        .i_base_pointer_pair(hl), .i_index_pair(de), .i_reg_b(rb), .i_reg_c(rc),
        .i_stack_pointer(sp), .o_valid(o_valid), .o_operand(o));
    regfile_model partner (.i_clock(i_clock), .i_wr(wr), .i_wr_sel(wr_sel),
        .i_wr_data(wr_data), .i_sp_wr(sp_wr), .i_sp_data(sp_data),
        .i_bank_select_bit_low(bsl), .i_bank_select_bit_high(bsh),
        .o_base_pointer_pair(hl), .o_index_pair(de), .o_reg_b(rb), .o_reg_c(rc),
        .o_stack_pointer(sp));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [19:0] e, input logic [19:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask : chk
    function automatic opaddr_pkg::decode_req_t mk(input opaddr_pkg::addr_mode_t m,
                                                   input logic [15:0] imm);
        mk = '0;
        mk.mode = m;
        mk.imm = imm;
    endfunction : mk
    // Request held one cycle; answer checked at the next falling edge
    task automatic send(input opaddr_pkg::decode_req_t r);
        i_valid = 1'b1;
        i_req = r;
        @(negedge i_clock);
        chk("o_valid", 20'h1, {19'h0, o_valid});
    endtask : send
    task automatic idle();
        i_valid = 1'b0;
        @(negedge i_clock);
        chk("o_valid idle", 20'h0, {19'h0, o_valid});
    endtask : idle
    task automatic mchk(input logic m, input logic u, input logic [15:0] a);
        chk("addr", {2'h0, m, u, a}, {2'h0, o.misaligned, o.unmapped, o.addr});
    endtask : mchk
    task automatic wr_reg(input logic [4:0] s, input logic [7:0] d);
        wr = 1'b1;
        wr_sel = s;
        wr_data = d;
        @(negedge i_clock);
    endtask : wr_reg
    // Load base pair, index pair, B and C of one bank
    task automatic load(input logic [1:0] b, input logic [15:0] h, input logic [15:0] d,
                        input logic [7:0] vb, input logic [7:0] vc);
        wr_reg({b, 3'h7}, h[15:8]);
        wr_reg({b, 3'h6}, h[7:0]);
        wr_reg({b, 3'h5}, d[15:8]);
        wr_reg({b, 3'h4}, d[7:0]);
        wr_reg({b, 3'h3}, vb);
        wr_reg({b, 3'h2}, vc);
        wr = 1'b0;
        {bsh, bsl} = b;
    endtask : load
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_implied();
        opaddr_pkg::decode_req_t r;
        logic                    md;
        {bsh, bsl} = 2'h2;
        for (int k = 1; k < 7; k++) begin
            r = mk(opaddr_pkg::mode_implied, 16'h0);
            r.imp_op = opaddr_pkg::implied_op_t'(k);
            md = (k < 3);
            send(r);
            chk("implied src", {15'h0, 2'h2, k == 2 ? 3'h0 : opaddr_pkg::REG_A},
                {15'h0, o.reg_abs});
            if (md) chk("implied dst", {14'h0, 1'b1, 5'h10}, {14'h0, o.dest_pair, o.dest_abs});
            chk("implied pair", {19'h0, k == 2}, {19'h0, o.is_pair});
        end
        idle();
        $display("test implied done");
    endtask : t_implied
    task automatic t_register();
        opaddr_pkg::decode_req_t r;
        for (int k = 0; k < 32; k++) begin
            {bsh, bsl} = k[4:3];
            r = mk(opaddr_pkg::mode_register, 16'h0);
            r.reg_field = k[2:0];
            send(r);
            chk("reg_abs", {14'h0, 1'b1, k[4:0]}, {14'h0, o.is_reg, o.reg_abs});
        end
        // Register pairs by number, current bank
        for (int k = 0; k < 4; k++) begin
            r = mk(opaddr_pkg::mode_register, 16'h0);
            r.word = 1'b1;
            r.pair_field = k[1:0];
            send(r);
            chk("pair_abs", {14'h0, 1'b1, 2'h3, k[1:0], 1'b0},
                {14'h0, o.is_pair, o.reg_abs});
        end
        idle();
        $display("test register done");
    endtask : t_register
    // Table of immediate, word flag and expected flags/address per mode
    task automatic t_imm(input opaddr_pkg::addr_mode_t m, input logic [15:0] v,
                         input logic w, input logic mis, input logic un, input logic [15:0] a);
        opaddr_pkg::decode_req_t r;
        r = mk(m, v);
        r.word = w;
        send(r);
        mchk(mis, un, a);
    endtask : t_imm
    task automatic t_stack(input logic [15:0] s);
        opaddr_pkg::decode_req_t r;
        sp_wr = 1'b1;
        sp_data = s;
        @(negedge i_clock);
        sp_wr = 1'b0;
        for (int k = 0; k < 5; k++) begin
            r = mk(opaddr_pkg::mode_stack, 16'h0);
            r.stk_op = opaddr_pkg::stack_op_t'(k);
            send(r);
            mchk(1'b0, s < 16'hfe20 || s > 16'hfeff, s);
            chk("is_stack", 20'h1, {19'h0, o.is_stack});
        end
        idle();
    endtask : t_stack
    task automatic t_based();
        opaddr_pkg::decode_req_t r;
        load(2'h1, 16'hfff0, 16'h1234, 8'h12, 8'h80);
        r = mk(opaddr_pkg::mode_reg_indirect, 16'h0);
        r.pair_field = opaddr_pkg::PAIR_DE;
        send(r);
        mchk(1'b0, 1'b0, 16'h1234);
        r.pair_field = opaddr_pkg::PAIR_BASE;
        send(r);
        mchk(1'b0, 1'b0, 16'hfff0);
        send(mk(opaddr_pkg::mode_based, 16'h0020));
        mchk(1'b0, 1'b0, 16'h0010);
        r = mk(opaddr_pkg::mode_based_indexed, 16'h0);
        send(r);
        mchk(1'b0, 1'b0, 16'h0002);
        r.use_c_index = 1'b1;
        send(r);
        mchk(1'b0, 1'b0, 16'h0070);
        r = mk(opaddr_pkg::mode_direct, 16'h5555);
        r.opcode = opaddr_pkg::OPC_LOAD_A_BASE_B;
        send(r);
        mchk(1'b0, 1'b0, 16'h0002);
        chk("load dest", {15'h0, 2'h1, opaddr_pkg::REG_A}, {15'h0, o.dest_abs});
        idle();
        $display("test based done");
    endtask : t_based
    // ****************************************************************
    // Main sequence, timeout and verdict
    // ****************************************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        {i_srst, i_valid, wr, sp_wr, bsl, bsh} = 6'h21;
        {wr_sel, wr_data, sp_data, cycles, failures, check_count} = '0;
        i_req = '0;
        repeat (10) @(negedge i_clock);
        chk("reset out", 20'h0, {19'h0, o_valid | (|o)});
        i_srst = 1'b0;
        t_implied();
        t_register();
        t_imm(opaddr_pkg::mode_direct, 16'hfe00, 1'b0, 1'b0, 1'b0, 16'hfe00);
        t_imm(opaddr_pkg::mode_direct, 16'hffff, 1'b0, 1'b0, 1'b0, 16'hffff);
        t_imm(opaddr_pkg::mode_short_direct, 16'h0000, 1'b0, 1'b0, 1'b0, 16'hff00);
        t_imm(opaddr_pkg::mode_short_direct, 16'h001f, 1'b0, 1'b0, 1'b0, 16'hff1f);
        t_imm(opaddr_pkg::mode_short_direct, 16'h0020, 1'b0, 1'b0, 1'b0, 16'hfe20);
        t_imm(opaddr_pkg::mode_short_direct, 16'h00ff, 1'b0, 1'b0, 1'b0, 16'hfeff);
        t_imm(opaddr_pkg::mode_short_direct, 16'h0031, 1'b1, 1'b1, 1'b0, 16'hfe31);
        t_imm(opaddr_pkg::mode_special_reg, 16'h00cf, 1'b0, 1'b0, 1'b0, 16'hffcf);
        t_imm(opaddr_pkg::mode_special_reg, 16'h00d0, 1'b0, 1'b0, 1'b1, 16'hffd0);
        t_imm(opaddr_pkg::mode_special_reg, 16'h00df, 1'b0, 1'b0, 1'b1, 16'hffdf);
        t_imm(opaddr_pkg::mode_special_reg, 16'h00e0, 1'b0, 1'b0, 1'b0, 16'hffe0);
        t_imm(opaddr_pkg::mode_special_reg, 16'h00e1, 1'b1, 1'b1, 1'b0, 16'hffe1);
        idle();
        chk("addr holds", 20'hffe1, {4'h0, o.addr});
        $display("test immediate modes done");
        t_based();
        t_stack(16'hfe20);
        t_stack(16'hff00);
        $display("test stack done");
        wrap_up();
    end
endmodule : operand_address_generator_tb_top
